// ---- hdl/wdt_pkg.sv ----
package wdt_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_TIME_NS = 1000;
  localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_MIN_MS = 16;
  localparam int TIMEOUT_MAX_MS = 2100;
  localparam int CFG_SETTLE_CYCLES = 2;
  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int SEL_W = 3;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] BASE_TICKS = CNT_W'(TIMEOUT_MIN_MS * 1000 / TICK_TIME_US);
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h7;
  localparam logic [7:0] FEED_KEY_FIRST = 8'h1E;
  localparam logic [7:0] FEED_KEY_SECOND = 8'hE1;
  localparam int RST_CNT_W = 8;
endpackage

// ---- hdl/wdt_prescaler.sv ----
`timescale 1ns/100ps
module wdt_prescaler #(
  parameter int DIV = wdt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output logic tick
);
  logic [31:0] div_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 32'h0;
      tick <= 1'b0;
    end else if (!run) begin
      div_reg <= 32'h0;
      tick <= 1'b0;
    end else if (div_reg == 32'(DIV - 1)) begin
      div_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // wdt_prescaler

// ---- hdl/wdt_top.sv ----
// Functional notes
// R1 - In watchdog role the timer runs from its own clock, not the CPU clock.
// R2 - Watchdog role: software feeds regularly or CPU is reset; no way to stop it.
// R3 - With role disabled the timer serves as interval timer raising an interrupt.
// R4 - Timeout chosen by three-bit select, eight periods from 16 ms to about 2.1 s.
// R5 - Watchdog role: control register written once at init; later writes ignored.
// R6 - Software feeds first, then writes select; init safe within 10 ms.
// R7 - CPU oscillator stopping does not stop watchdog; it still resets the CPU.
// R8 - Chip reset from another source temporarily deactivates the watchdog timer.
// R9 - Feed is key 1Eh then E1h to feed register; only that pair restarts count.
// R10 - Other activity between the two key writes is allowed.
// R11 - Wrong or partial sequence does nothing; timeout keeps original schedule.
// R12 - Watchdog timeout asserts internal reset about one microsecond.
// R13 - Timeout in power-down restarts oscillator, holds execution until stable.
// R14 - Interval role: timeout sets overflow flag, requests interrupt, restarts count.
// R15 - After a good feed the key tracker waits again for the first key.
`timescale 1ns/100ps
module wdt_top #(
  parameter int TICK_DIV = wdt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic watchdog_role_enable_cfg,
  input wire logic chip_reset_req,
  input wire logic power_down,
  input wire logic osc_stable,
  input wire logic feed_wr,
  input wire logic [7:0] feed_data,
  input wire logic ctrl_wr,
  input wire logic [wdt_pkg::SEL_W-1:0] ctrl_data,
  input wire logic flag_clr,
  output logic cpu_reset_out,
  output logic osc_start_out,
  output logic exec_hold_out,
  output logic overflow_flag,
  output logic irq_out,
  output logic [wdt_pkg::SEL_W-1:0] timeout_select_field,
  output logic role_out
);
  // ----------------------------------------------------------------
  // Synchronisers and strap capture
  // ----------------------------------------------------------------
  logic ext_s1_reg, ext_s2_reg, pd_s1_reg, pd_s2_reg, st_s1_reg, st_s2_reg;
  logic cfg_s1_reg, cfg_s2_reg;
  logic [2:0] cfg_cnt_reg;
  logic cfg_done;
  logic [wdt_pkg::RST_CNT_W-1:0] rst_cnt_reg;
  logic [wdt_pkg::CNT_W-1:0] count_reg, limit;
  logic key1_seen_reg, sel_locked_reg, timeout_evt, feed_ok, run, tick;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {ext_s1_reg, ext_s2_reg, pd_s1_reg, pd_s2_reg} <= 4'h0;
      {st_s1_reg, st_s2_reg, cfg_s1_reg, cfg_s2_reg} <= 4'h0;
    end else begin
      ext_s1_reg <= chip_reset_req;
      ext_s2_reg <= ext_s1_reg;
      pd_s1_reg <= power_down;
      pd_s2_reg <= pd_s1_reg;
      st_s1_reg <= osc_stable;
      st_s2_reg <= st_s1_reg;
      cfg_s1_reg <= watchdog_role_enable_cfg;
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  // Two sync stages, then settle, so the strap is seen before capture ends
  assign cfg_done = (cfg_cnt_reg == 3'(wdt_pkg::CFG_SETTLE_CYCLES + 2));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_cnt_reg <= 3'h0;
      role_out <= 1'b0;
    end else if (!cfg_done) begin
      cfg_cnt_reg <= cfg_cnt_reg + 3'h1;
      role_out <= cfg_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Feed key tracker
  // ----------------------------------------------------------------
  assign feed_ok = feed_wr && key1_seen_reg && feed_data == wdt_pkg::FEED_KEY_SECOND; // R9

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key1_seen_reg <= 1'b0;
    end else if (feed_wr) begin
      key1_seen_reg <= (feed_data == wdt_pkg::FEED_KEY_FIRST); // R9 R10 R15
    end
  end

  // ----------------------------------------------------------------
  // Timeout select, locked once in watchdog role
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_select_field <= wdt_pkg::SEL_RESET;
      sel_locked_reg <= 1'b0;
    end else if (cpu_reset_out || ext_s2_reg) begin
      timeout_select_field <= wdt_pkg::SEL_RESET;
      sel_locked_reg <= 1'b0;
    end else if (ctrl_wr && cfg_done && !(role_out && sel_locked_reg)) begin
      timeout_select_field <= ctrl_data; // R4 R5
      sel_locked_reg <= role_out;
    end
  end

  // ----------------------------------------------------------------
  // Timeout counter on the block's own clock
  // ----------------------------------------------------------------
  assign run = cfg_done && !ext_s2_reg && !cpu_reset_out; // R1 R2 R7 R8
  assign limit = wdt_pkg::BASE_TICKS << timeout_select_field; // R4
  // Select shrunk below the count: expire on the next tick, no wrap
  assign timeout_evt = run && tick && !feed_ok && count_reg >= limit - 12'h1;

  wdt_prescaler #(.DIV(TICK_DIV)) u_presc (
    .clk(clk),
    .reset_n(reset_n),
    .run(run),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else if (!run || feed_ok || timeout_evt) begin
      count_reg <= '0; // R8 R9 R14
    end else if (tick) begin
      count_reg <= count_reg + 12'h1; // R11
    end
  end

  // ----------------------------------------------------------------
  // Watchdog reset and power-down wake
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_reg <= '0;
      cpu_reset_out <= 1'b0;
    end else if (timeout_evt && role_out) begin
      rst_cnt_reg <= wdt_pkg::RST_CNT_W'(wdt_pkg::RST_CYCLES - 1); // R2 R12
      cpu_reset_out <= 1'b1;
    end else if (rst_cnt_reg != '0) begin
      rst_cnt_reg <= rst_cnt_reg - 8'h1;
    end else begin
      cpu_reset_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_start_out <= 1'b0;
      exec_hold_out <= 1'b0;
    end else if (timeout_evt && role_out && pd_s2_reg) begin
      osc_start_out <= 1'b1; // R13
      exec_hold_out <= 1'b1;
    end else if (exec_hold_out && st_s2_reg && !cpu_reset_out) begin
      osc_start_out <= 1'b0; // R13
      exec_hold_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interval role overflow flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag <= 1'b0;
      irq_out <= 1'b0;
    end else if (timeout_evt && !role_out) begin
      overflow_flag <= 1'b1; // R3 R14
      irq_out <= 1'b1;
    end else if (flag_clr) begin
      overflow_flag <= 1'b0;
      irq_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_feed_restarts: assert property (@(posedge clk) disable iff (!reset_n) // R9
    run && feed_ok |=> count_reg == '0)
    else $error("feed did not restart count");
  chk_key_rearm: assert property (@(posedge clk) disable iff (!reset_n) // R15
    feed_ok |=> !key1_seen_reg)
    else $error("tracker not rearmed after feed");
  chk_bad_key_nop: assert property (@(posedge clk) disable iff (!reset_n) // R11
    run && feed_wr && !feed_ok && !tick && !timeout_evt |=> count_reg == $past(count_reg))
    else $error("wrong key disturbed count");
  chk_reset_width: assert property (@(posedge clk) disable iff (!reset_n) // R12
    $rose(cpu_reset_out) |-> ##99 cpu_reset_out ##1 !cpu_reset_out)
    else $error("watchdog reset width wrong");
  chk_wd_timeout_rst: assert property (@(posedge clk) disable iff (!reset_n) // R2
    timeout_evt && role_out |=> cpu_reset_out && !overflow_flag)
    else $error("watchdog timeout without reset");
  chk_interval_flag: assert property (@(posedge clk) disable iff (!reset_n) // R14
    timeout_evt && !role_out |=> overflow_flag && irq_out && !cpu_reset_out && count_reg == '0)
    else $error("interval timeout wrong");
  chk_sel_locked: assert property (@(posedge clk) disable iff (!reset_n) // R5
    role_out && sel_locked_reg && ctrl_wr && !cpu_reset_out && !ext_s2_reg
    |=> $stable(timeout_select_field))
    else $error("locked select changed");
  chk_ext_reset_hold: assert property (@(posedge clk) disable iff (!reset_n) // R8
    ext_s2_reg |=> count_reg == '0)
    else $error("count ran during chip reset");
  chk_pd_wake_hold: assert property (@(posedge clk) disable iff (!reset_n) // R13
    exec_hold_out && !st_s2_reg |=> exec_hold_out && osc_start_out)
    else $error("hold released before oscillator stable");
  chk_hold_release: assert property (@(posedge clk) disable iff (!reset_n) // R13
    exec_hold_out && st_s2_reg && !cpu_reset_out && !(timeout_evt && role_out && pd_s2_reg)
    |=> !exec_hold_out && !osc_start_out)
    else $error("hold kept after oscillator stable");
  chk_role_hold: assert property (@(posedge clk) disable iff (!reset_n) // R3
    cfg_done |=> $stable(role_out))
    else $error("role changed after capture");
  chk_role_no_flag: assert property (@(posedge clk) disable iff (!reset_n) // R3
    role_out |-> !overflow_flag && !irq_out)
    else $error("interval flag in watchdog role");
  chk_flag_clear: assert property (@(posedge clk) disable iff (!reset_n) // R14
    flag_clr && !(timeout_evt && !role_out) |=> !overflow_flag && !irq_out)
    else $error("flag clear ignored");
  chk_sel_chip_rst: assert property (@(posedge clk) disable iff (!reset_n) // R8
    ext_s2_reg |=> timeout_select_field == wdt_pkg::SEL_RESET)
    else $error("select not reset by chip reset");
endmodule // wdt_top

// ---- verification/wdt_top_test.sv ----
`timescale 1ns/100ps
module wdt_top_test;
  localparam int TD = 4;
  localparam int TOL = 2 * TD + 4;
  logic clk, reset_n, cfg, creq, pd, ostab, fwr, cwr, fclr;
  logic crst, ostart, hold, ovf, irq, role;
  logic [7:0] fd;
  logic [wdt_pkg::SEL_W-1:0] cd, sel;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0 = 0;
  int per = 0;
  int mk = 0;
  int n;
  wdt_top #(.TICK_DIV(TD)) dut (.clk(clk), .reset_n(reset_n),
    .watchdog_role_enable_cfg(cfg), .chip_reset_req(creq), .power_down(pd),
    .osc_stable(ostab), .feed_wr(fwr), .feed_data(fd), .ctrl_wr(cwr), .ctrl_data(cd),
    .flag_clr(fclr), .cpu_reset_out(crst), .osc_start_out(ostart), .exec_hold_out(hold),
    .overflow_flag(ovf), .irq_out(irq), .timeout_select_field(sel), .role_out(role));
  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic results;
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic chk_t(input int g, input int e, input int tol, input string m);
    cmp_count++;
    if (g < e - tol || g > e + tol) begin
      n_errors++;
      $display("Error %0t: %s got %0d want %0d", $time, m, g, e);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wt(input int w, input int lim, output int c);
    c = 0;
    while (c < lim && !(w == 0 ? crst === 1'b1 : w == 1 ? ovf === 1'b1 :
           w == 2 ? hold === 1'b0 : crst === 1'b0)) begin
      tk(1);
      c++;
    end
    if (c >= lim) begin
      n_errors++;
      $display("Error %0t: wait ran out", $time);
      results();
    end
  endtask
  task automatic quiet(input int k);
    repeat (k) begin
      tk(1);
      chk(crst, 1'b0, "unexpected reset");
    end
  endtask
  // Feed write with the key tracker of the model
  task automatic fw(input logic [7:0] b);
    fwr = 1;
    fd = b;
    tk(1);
    fwr = 0;
    if (mk == 1 && b == 8'hE1) t0 = cyc;
    mk = (b == 8'h1E);
    tk(1);
  endtask
  task automatic cw(input logic [2:0] v);
    cwr = 1;
    cd = v;
    tk(1);
    cwr = 0;
    tk(1);
  endtask
  task automatic rst(input logic r);
    reset_n = 0;
    cfg = r;
    mk = 0;
    tk(12);
    reset_n = 1;
    tk(4);
    chk(role, r, "role");
    chk(sel, 3'h7, "select reset");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    n = $urandom(5587);
    {creq, pd, fwr, cwr, fclr, fd, cd} = '0;
    ostab = 1;
    rst(1);
    fw(8'h1E);
    fw(8'hE1);
    cw(3'h0);
    cw(3'h5);
    chk(sel, 3'h0, "select locked");
    per = 16 * TD;
    repeat (6) begin
      fw(8'h1E);
      cw(3'($urandom));
      fw(8'hE1);
      quiet(per / 2);
    end
    chk(sel, 3'h0, "select locked");
    fw(8'hE1);
    fw(8'h1E);
    fw(8'h55);
    fw(8'hE1);
    wt(0, 300, n);
    chk_t(cyc, t0 + per, TOL, "timeout time");
    wt(3, 300, n);
    chk_t(n, 100, 1, "reset width");
    cw(3'h0);
    creq = 1;
    quiet(3 * per);
    chk(sel, 3'h7, "select reset by chip reset");
    creq = 0;
    rst(1);
    fw(8'h1E);
    fw(8'hE1);
    cw(3'h0);
    pd = 1;
    ostab = 0;
    wt(0, 300, n);
    chk_t(cyc, t0 + per, TOL, "timeout with osc stopped");
    wt(3, 300, n);
    chk(ostart, 1'b1, "osc restart");
    chk(hold, 1'b1, "exec hold");
    pd = 0;
    ostab = 1;
    wt(2, 20, n);
    rst(0);
    cw(3'h1);
    t0 = cyc;
    per = 32 * TD;
    wt(1, 400, n);
    chk_t(cyc, t0 + per, TOL, "interval time");
    chk(irq, 1'b1, "interrupt");
    t0 = cyc;
    fclr = 1;
    tk(1);
    fclr = 0;
    chk(ovf, 1'b0, "flag clear");
    chk(irq, 1'b0, "interrupt clear");
    wt(1, 400, n);
    chk_t(cyc, t0 + per, TOL, "interval restart");
    chk(crst, 1'b0, "no reset in interval role");
    results();
  end
endmodule // wdt_top_test
